// ===== dv/sp_link_partner.sv
// Far-side serial device: shift register peripheral in mode 0, plain UART in async mode.
// Assumes the bench routes the data pin and sets the mode; bit time is a parameter in clocks.
`timescale 1ns/1ns
module sp_link_partner
#(
  parameter int BIT_CLOCKS = 192
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bench control.
  input  wire logic       asyncMode,
  input  wire logic       sendGo,
  input  wire logic [7:0] sendByte,
  // Device pins.
  input  wire logic       portLineClock,
  input  wire logic       portLineDataOut,
  input  wire logic       portLineDataOe,
  output logic            partnerData,
  // Captured word, stop bit above the byte in async mode, a fixed one above it in shift mode.
  output logic            capValid,
  output logic [8:0]      capWord
);
  logic       lastClk; // Line level at the previous edge.
  logic [8:0] word;    // Capture shifter.
  logic [9:0] frame;   // Outgoing async frame.
  int         nBits;   // Shift-mode bits captured so far.

  // Capture process: shift mode on rising shift clock, async by mid-bit sampling.
  initial
  begin
    capValid = 1'b0;
    capWord  = 9'h000;
    lastClk  = 1'b1;
    nBits    = 0;
    word     = 9'h000;
    forever
    begin
      @(posedge clock);
      capValid <= 1'b0;
      if (!rst_n)
        nBits = 0;
      if (asyncMode && lastClk && !portLineClock)
      begin
        // Centre on the start bit, then take eight data bits and the stop bit.
        repeat (BIT_CLOCKS / 2) @(posedge clock);
        for (int k = 0; k < 9; k++)
        begin
          repeat (BIT_CLOCKS) @(posedge clock);
          word = {portLineClock, word[8:1]};
        end
        capWord  <= word;
        capValid <= 1'b1;
      end
      else if (!asyncMode && !lastClk && portLineClock && portLineDataOe)
      begin
        word = {1'b1, portLineDataOut, word[7:1]};
        nBits++;
        if (nBits == 8)
        begin
          capWord  <= word;
          capValid <= 1'b1;
          nBits = 0;
        end
      end
      lastClk = portLineClock;
    end
  end

  // Sender: holds each bit only as long as it must, then lets the line wander in shift mode and idles it high in async mode.
  initial
  begin
    partnerData = 1'b1;
    forever
    begin
      @(posedge clock);
      if (sendGo && asyncMode)
      begin
        frame = {1'b1, sendByte, 1'b0};
        for (int j = 0; j < 10; j++)
        begin
          partnerData <= frame[j];
          repeat (BIT_CLOCKS) @(posedge clock);
        end
      end
      else if (sendGo)
      begin
        // New bit after each falling shift clock, held past the next rise.
        for (int j = 0; j < 8; j++)
        begin
          @(negedge portLineClock);
          partnerData <= sendByte[7 - j];
        end
        @(posedge portLineClock);
      end
      else
        partnerData <= asyncMode ? 1'b1 : ~partnerData;
    end
  end
endmodule // sp_link_partner

// ===== dv/tb_sp_serial_port.sv
// Self-checking bench for the serial port: APB master, link partner, queued expectations.
// Assumes the package and the partner model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %0h want %0h", $time, g, e); end num_checks++;
module tb_sp_serial_port;
  import sp_pkg::*;
  logic        clock;
  logic        rst_n;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dataOut;
  logic        dataOe;
  logic        lineClock;
  logic        serialEvent;
  logic        partnerData;
  logic        asyncMode;
  logic        sendGo;
  logic [7:0]  sendByte;
  logic        capValid;
  logic [8:0]  capWord;
  logic [32:0] expRd[$];   // Expected {pslverr, prdata} per read.
  logic [8:0]  expLink[$]; // Expected words at the partner.
  int          n_errors;
  int          num_checks;
  int          seed;
  int          waited;
  logic [7:0]  dataByte;
  // The port drives the data pin while it enables; the partner drives it otherwise.
  wire         dataPin = dataOe ? dataOut : partnerData;

  sp_serial_port i_sp_serial_port (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portLineDataIn(dataPin), .portLineDataOut(dataOut),
    .portLineDataOe(dataOe), .portLineClock(lineClock), .serialEvent(serialEvent));

  sp_link_partner i_sp_link_partner (.clock(clock), .rst_n(rst_n), .asyncMode(asyncMode),
    .sendGo(sendGo), .sendByte(sendByte), .portLineClock(lineClock), .portLineDataOut(dataOut),
    .portLineDataOe(dataOe), .partnerData(partnerData), .capValid(capValid), .capWord(capWord));

  // Clock, 10 ns period.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Verdict and end of run.
  task automatic results();
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic timeout();
    n_errors++;
    $display("[FAIL] %0t wait limit reached", $time);
    results();
  endtask

  // One APB transfer; request held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int t;
    t = 0;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 50)
      timeout();
  endtask

  task automatic rd(input logic [7:0] addr, input logic [32:0] e);
    expRd.push_back(e);
    apb(1'b0, addr, 32'h0);
  endtask

  task automatic partnerSend(input logic [7:0] b);
    sendByte <= b;
    sendGo   <= 1'b1;
    @(posedge clock);
    sendGo <= 1'b0;
  endtask

  // Bounded wait for the event request; counts edges in waited.
  task automatic waitEvent();
    waited = 0;
    while (serialEvent !== 1'b1)
    begin
      @(posedge clock);
      waited++;
      if (waited > 20000)
        timeout();
    end
  endtask

  // Monitor: each result takes the oldest note of its kind.
  always @(posedge clock)
  begin
    logic [32:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expRd.pop_front();
      `CHK({pslverr, prdata}, e)
    end
    if (capValid === 1'b1)
    begin
      e = {24'h0, expLink.pop_front()};
      `CHK({24'h0, capWord}, e)
    end
  end

  // Main sequence.
  initial
  begin
    seed = 32'h0f541953;
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    asyncMode = 1'b0;
    sendGo = 1'b0;
    sendByte = 8'h00;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(CTRL_OFFSET, 33'h0);
    rd(BAUD_OFFSET, 33'h0);
    rd(8'h0c, 33'h100000000);
    // Shift-mode send, timed from the buffer write to the event request.
    dataByte = $random(seed);
    expLink.push_back({1'b1, dataByte});
    apb(1'b1, BUFFER_OFFSET, {24'h0, dataByte});
    waitEvent();
    `CHK(waited inside {[105:125]}, 1'b1)
    rd(CTRL_OFFSET, 33'h2);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (3) @(posedge clock);
    `CHK(serialEvent, 1'b0)
    // Shift-mode receive; first bit in lands in bit 7.
    dataByte = $random(seed);
    partnerSend(dataByte);
    apb(1'b1, CTRL_OFFSET, 32'h10);
    waitEvent();
    rd(CTRL_OFFSET, 33'h11);
    rd(BUFFER_OFFSET, {25'h0, dataByte});
    apb(1'b1, CTRL_OFFSET, 32'h0);
    // Async mode: reload ff with doubler gives 16 machine cycles a bit.
    // Eight-bit auto-reload with no timer interrupt; the readback stands for a software reload.
    apb(1'b1, BAUD_OFFSET, 32'h3ff);
    rd(BAUD_OFFSET, 33'h3ff);
    apb(1'b1, CTRL_OFFSET, 32'h40);
    asyncMode <= 1'b1;
    dataByte = $random(seed);
    expLink.push_back({1'b1, dataByte});
    apb(1'b1, BUFFER_OFFSET, {24'h0, dataByte});
    waitEvent();
    rd(CTRL_OFFSET, 33'h42);
    apb(1'b1, CTRL_OFFSET, 32'h50);
    repeat (400) @(posedge clock);
    // Async receive; stop bit lands in the ninth-bit field.
    dataByte = $random(seed);
    partnerSend(dataByte);
    waitEvent();
    rd(CTRL_OFFSET, 33'h55);
    rd(BUFFER_OFFSET, {25'h0, dataByte});
    repeat (10) @(posedge clock);
    `CHK(expLink.size(), 0)
    `CHK(expRd.size(), 0)
    results();
  end
endmodule // tb_sp_serial_port

// ===== shared/sp_pkg.sv
// Constants shared by the serial port and its baud timer.
// Assumes a 100 MHz clock taken as the oscillator, twelve clocks to one machine cycle.
package sp_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] BUFFER_OFFSET = 8'h04;
  localparam logic [7:0] BAUD_OFFSET   = 8'h08;

  // Field positions in the control register.
  localparam int RXDONE_BIT = 0;
  localparam int TXDONE_BIT = 1;
  localparam int NINTH_BIT  = 2;
  localparam int RXEN_BIT   = 4;
  localparam int MODE_LSB   = 6;

  // Field positions in the baud register.
  localparam int DOUBLER_BIT = 8;
  localparam int RUN_BIT     = 9;

  // Values after reset.
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [7:0] RELOAD_RESET = 8'h00;

  // Serial modes.
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC = 2'h1;

  // State phases of one machine cycle, counted 0 to 11 from S1P1.
  localparam logic [3:0] PHASE_S1P1 = 4'h0;
  localparam logic [3:0] PHASE_S1P2 = 4'h1;
  localparam logic [3:0] PHASE_S3P1 = 4'h4;
  localparam logic [3:0] PHASE_S5P2 = 4'h9;
  localparam logic [3:0] PHASE_S6P1 = 4'ha;
  localparam logic [3:0] PHASE_S6P2 = 4'hb;

  // Shifter load patterns and divider points.
  localparam logic [8:0] RX_LOAD_SYNC  = 9'h0fe;
  localparam logic [8:0] RX_LOAD_ASYNC = 9'h1ff;
  localparam logic [3:0] DIV_LAST      = 4'hf;
  localparam logic [3:0] DIV_MID       = 4'h7;
  localparam logic [7:0] TIMER_TOP     = 8'hff;

  // Asynchronous receive states.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sp_arx_type;

endpackage

// ===== verilog/sp_baud_timer.sv
// Eight-bit auto-reload baud timer that yields the sixteen-times bit rate tick.
// Assumes a one-clock strobe once per machine cycle from the serial port.
`timescale 1ns/1ns
module sp_baud_timer
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Setup from the baud register.
  input  wire logic       timerRun,
  input  wire logic [7:0] reloadValue,
  input  wire logic       doubler,
  // Machine cycle strobe in, sample tick out.
  input  wire logic       cycleStrobe,
  output logic            tick16
);
  import sp_pkg::*;

  logic [7:0] count;    // Timer count, counts up once per machine cycle.
  logic       half;     // Halves the overflow rate while the doubler is clear.
  wire        overflow = timerRun & cycleStrobe & (count == TIMER_TOP);

  // The count reloads on overflow, as in the usual auto-reload setup.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count  <= 8'h00;
      half   <= 1'b0;
      tick16 <= 1'b0;
    end
    else
    begin
      if (overflow)
        count <= reloadValue;
      else if (timerRun & cycleStrobe)
        count <= 8'(count + 8'h01);
      if (overflow)
        half <= ~half;
      // Bit rate follows overflow rate and the doubler.
      tick16 <= overflow & (doubler | half);
    end
  end

endmodule // sp_baud_timer

// ===== verilog/sp_serial_port.sv
// Serial port with the synchronous shift mode and the asynchronous 10-bit mode, on APB.
// Assumes the clock is the oscillator; pins are synchronised here before use.
`timescale 1ns/1ns
module sp_serial_port
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Data pin, two-way in shift mode, input in async mode.
  input  wire logic        portLineDataIn,
  output logic             portLineDataOut,
  output logic             portLineDataOe,
  // Shift clock in shift mode, transmit line in async mode.
  output logic             portLineClock,
  // Serial event request.
  output logic             serialEvent
);
  import sp_pkg::*;

  // Shifts a 9-bit value right, filling with the given bit.
  function automatic logic [8:0] shiftRight(input logic [8:0] value, input logic fill);
    shiftRight = {fill, value[8:1]};
  endfunction

  // Machine cycle phase counter.
  logic [3:0] phase;
  wire        cycleEnd  = (phase == PHASE_S6P2);
  wire  [3:0] nextPhase = cycleEnd ? PHASE_S1P1 : 4'(phase + 4'h1);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase <= PHASE_S1P1;
    else
      phase <= nextPhase;
  end

  // Two-stage synchroniser on the data pin.
  logic dataMeta;   // First stage, read only by the second.
  logic dataSync;   // Safe copy of the pin.

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataMeta <= 1'b1;
      dataSync <= 1'b1;
    end
    else
    begin
      dataMeta <= portLineDataIn;
      dataSync <= dataMeta;
    end
  end

  // Software visible state.
  logic [1:0] mode;           // Serial mode select.
  logic       rxEnable;       // Reception enable.
  logic       receivedNinth;  // Received ninth bit.
  logic       txDone;         // Transmit done flag.
  logic       rxDone;         // Receive done flag.
  logic [7:0] serialBuffer;   // Received byte.
  logic [7:0] reloadValue;    // Baud timer reload.
  logic       baudDoubler;    // Baud doubler.
  logic       timerRun;       // Baud timer run.

  // APB decode; one wait state so that read data comes from a flip-flop.
  wire access   = psel & penable & pready;
  wire hitCtrl  = (paddr == CTRL_OFFSET);
  wire hitBuf   = (paddr == BUFFER_OFFSET);
  wire hitBaud  = (paddr == BAUD_OFFSET);
  wire mapped   = hitCtrl | hitBuf | hitBaud;
  wire wrCtrl   = access & pwrite & hitCtrl;
  wire wrBuf    = access & pwrite & hitBuf;
  wire wrBaud   = access & pwrite & hitBaud;
  wire syncMode = (mode == MODE_SHIFT);
  wire asyncMode = (mode == MODE_ASYNC);
  wire [31:0] ctrlValue = {24'h000000, mode, 1'b0, rxEnable, 1'b0, receivedNinth, txDone, rxDone};
  wire [31:0] baudValue = {22'h000000, timerRun, baudDoubler, reloadValue};
  wire [31:0] readValue = hitCtrl ? ctrlValue : hitBuf ? {24'h000000, serialBuffer} :
                          hitBaud ? baudValue : 32'h00000000;

  // Bus answer registers; unmapped addresses answer with an error and zero data.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? readValue : 32'h00000000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Baud timer and sample tick.
  logic tick16;

  sp_baud_timer i_sp_baud_timer
  (
    .clock       (clock),
    .rst_n       (rst_n),
    .timerRun    (timerRun),
    .reloadValue (reloadValue),
    .doubler     (baudDoubler),
    .cycleStrobe (cycleEnd),
    .tick16      (tick16)
  );

  // Divide-by-16 counters; receive keeps its own so a start edge cannot disturb transmit.
  logic [3:0] txDiv;
  logic [3:0] rxDiv;
  logic       startEdge;
  wire        txRoll = tick16 & (txDiv == DIV_LAST);
  wire        rxMid  = tick16 & (rxDiv == DIV_MID);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txDiv <= 4'h0;
      rxDiv <= 4'h0;
    end
    else
    begin
      if (tick16)
        txDiv <= 4'(txDiv + 4'h1);
      if (startEdge)
        rxDiv <= 4'h0;
      else if (tick16)
        rxDiv <= 4'(rxDiv + 4'h1);
    end
  end

  // Transmit state.
  logic [8:0] txShift;      // Marker one above the byte, zeros fill from the left.
  logic       txPending;    // Buffer written, waiting for alignment.
  logic       txArm;        // Aligned, send starts at the next start point.
  logic       txSend;       // Transmit active.
  logic       txDataPhase;  // Shifter output drives the line.
  logic       txLast;       // Last shift done, send ends at S1P1.
  wire txFinal  = (txShift[8:2] == 7'h00) & txShift[1];
  wire txArmEv  = txPending & (syncMode ? cycleEnd : txRoll);
  wire txGo     = txArm & (syncMode ? cycleEnd : (phase == PHASE_S1P1));
  wire txStep   = txSend & (syncMode ? cycleEnd : (txRoll & txDataPhase));
  wire txEndAsync = asyncMode & txStep & txFinal;
  wire txEndSync  = syncMode & txLast & (phase == PHASE_S1P1);

  // Transmit control for both modes.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txShift     <= 9'h000;
      txPending   <= 1'b0;
      txArm       <= 1'b0;
      txSend      <= 1'b0;
      txDataPhase <= 1'b0;
      txLast      <= 1'b0;
    end
    else
    begin
      if (wrBuf)
        txShift <= {1'b1, pwdata[7:0]};
      else if (txStep)
        txShift <= shiftRight(txShift, 1'b0);
      // A rewrite during a frame reloads the shifter and the send under way goes on with the new byte; software waits for done.
      txPending <= wrBuf | (txPending & ~txArmEv);
      txArm     <= txArmEv | (txArm & ~txGo);
      if (txGo)
        txSend <= 1'b1;
      else if (txEndSync | txEndAsync)
        txSend <= 1'b0;
      if (asyncMode & txSend & txRoll & ~txDataPhase)
        txDataPhase <= 1'b1;
      else if (~txSend | txEndAsync)
        txDataPhase <= 1'b0;
      if (syncMode & txStep & txFinal)
        txLast <= 1'b1;
      else if (txEndSync)
        txLast <= 1'b0;
    end
  end

  // Receive state.
  logic [8:0] rxShift;      // Shared receive shifter.
  logic       rxArm;        // Shift mode start seen, load at next S6P2.
  logic       rxLoaded;     // Loaded, receive goes active next phase.
  logic       rxRecv;       // Shift mode receive active.
  logic       rxFin;        // Byte complete, flag at S1P1.
  logic       sampleBit;    // Data pin sampled at S5P2.
  logic       dataPrev;     // Line level at the previous tick.
  sp_arx_type rxState;      // Async receive state.
  wire rxStart0   = syncMode & rxEnable & ~rxDone & ~rxArm & ~rxLoaded & ~rxRecv & ~rxFin & cycleEnd;
  wire rxStep0    = syncMode & rxRecv & cycleEnd;
  wire rxDoneSync = syncMode & rxFin & (phase == PHASE_S1P1);
  wire rxStopHit  = asyncMode & (rxState == RX_STOP) & rxMid;
  wire rxDoneAsync = rxStopHit & ~rxDone;
  assign startEdge = asyncMode & rxEnable & (rxState == RX_IDLE) & tick16 & dataPrev & ~dataSync;

  // Shift mode receive sequence.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxArm     <= 1'b0;
      rxLoaded  <= 1'b0;
      rxRecv    <= 1'b0;
      rxFin     <= 1'b0;
      sampleBit <= 1'b1;
    end
    else
    begin
      rxArm    <= rxStart0 | (rxArm & ~cycleEnd);
      rxLoaded <= (rxArm & cycleEnd) | (rxLoaded & (phase != PHASE_S1P1));
      if (rxLoaded & (phase == PHASE_S1P1))
        rxRecv <= 1'b1;
      else if (rxDoneSync)
        rxRecv <= 1'b0;
      rxFin <= (rxStep0 & ~rxShift[7]) | (rxFin & ~rxDoneSync);
      if (rxRecv & (phase == PHASE_S5P2))
        sampleBit <= dataSync;
    end
  end

  // Receive shifter and async receive walk.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxShift  <= RX_LOAD_ASYNC;
      rxState  <= RX_IDLE;
      dataPrev <= 1'b1;
    end
    else
    begin
      if (tick16)
        dataPrev <= dataSync;
      if (rxArm & cycleEnd)
        rxShift <= RX_LOAD_SYNC;
      else if (rxStep0)
        rxShift <= {1'b0, rxShift[6:0], sampleBit};
      else if (startEdge)
        rxShift <= RX_LOAD_ASYNC;
      else if (rxMid & ((rxState == RX_START) | (rxState == RX_DATA)))
        rxShift <= shiftRight(rxShift, dataSync);
      case (rxState)
        RX_IDLE:
          if (startEdge)
            rxState <= RX_START;
        RX_START:
          // A start bit that is high again at mid-bit was noise.
          if (rxMid)
            rxState <= dataSync ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rxMid & ~rxShift[1])
            rxState <= RX_STOP;
        RX_STOP:
          if (rxMid)
            rxState <= RX_IDLE;
        default:
          rxState <= RX_IDLE;
      endcase
      if (~asyncMode)
        rxState <= RX_IDLE;
    end
  end

  // Software registers; a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode          <= MODE_RESET;
      rxEnable      <= 1'b0;
      receivedNinth <= 1'b0;
      txDone        <= 1'b0;
      rxDone        <= 1'b0;
      serialBuffer  <= 8'h00;
      reloadValue   <= RELOAD_RESET;
      baudDoubler   <= 1'b0;
      timerRun      <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
      begin
        mode     <= pwdata[MODE_LSB +: 2];
        rxEnable <= pwdata[RXEN_BIT];
      end
      if (wrBaud)
      begin
        reloadValue <= pwdata[7:0];
        baudDoubler <= pwdata[DOUBLER_BIT];
        timerRun    <= pwdata[RUN_BIT];
      end
      txDone <= txEndSync | txEndAsync | (wrCtrl ? pwdata[TXDONE_BIT] : txDone);
      rxDone <= rxDoneSync | rxDoneAsync | (wrCtrl ? pwdata[RXDONE_BIT] : rxDone);
      if (rxDoneAsync)
        receivedNinth <= dataSync;
      else if (wrCtrl)
        receivedNinth <= pwdata[NINTH_BIT];
      if (rxStep0 & ~rxShift[7])
        serialBuffer <= {rxShift[6:0], sampleBit};
      else if (rxDoneAsync)
        serialBuffer <= rxShift[8:1];
    end
  end

  // Pin drivers, registered; shift clock is worked out from the coming phase.
  wire clockLowPhase = (nextPhase >= PHASE_S3P1) & (nextPhase <= PHASE_S5P2);
  wire asyncLine     = txSend ? (txDataPhase & txShift[0]) : 1'b1;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portLineDataOut <= 1'b1;
      portLineDataOe  <= 1'b0;
      portLineClock   <= 1'b1;
      serialEvent     <= 1'b0;
    end
    else
    begin
      portLineDataOut <= txShift[0];
      portLineDataOe  <= syncMode & txSend;
      if (syncMode)
        portLineClock <= ~((txSend | rxRecv) & clockLowPhase);
      else
        portLineClock <= asyncLine;
      serialEvent <= txDone | rxDone;
    end
  end

  // Checks on the timing of the serial sequences.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_SHIFT_CLOCK_LOW: assert property (
    (syncMode && $past(txSend) && phase >= PHASE_S3P1 && phase <= PHASE_S5P2) |-> !portLineClock)
    else $error("Shift clock not low in S3 to S5 during send.");
  AST_TX_SHIFT_S6P2: assert property (
    (syncMode && txShift != $past(txShift) && !$past(wrBuf)) |-> $past(cycleEnd))
    else $error("Transmit shifter moved outside S6P2.");
  AST_TX_DONE_S1P1: assert property (
    ($rose(txDone) && syncMode) |-> (phase == PHASE_S1P2) && !txSend)
    else $error("Transmit done not set at S1P1 with send dropped.");
  AST_SEND_AFTER_ARM: assert property (
    ($rose(txSend) && syncMode) |-> $past(txArm) && $past(cycleEnd))
    else $error("Send rose without a machine cycle from the write.");
  AST_RX_LOAD: assert property (
    ($rose(rxRecv) && syncMode) |-> rxShift == RX_LOAD_SYNC && phase == PHASE_S1P2)
    else $error("Receive went active without the load pattern.");
  AST_RX_CLOCK_TOGGLE: assert property (
    (syncMode && $past(rxRecv) && (phase == PHASE_S3P1 || phase == PHASE_S6P1))
      |-> portLineClock == (phase == PHASE_S6P1))
    else $error("Receive shift clock level wrong at its toggle phases.");
  AST_RX_SHIFT_IN: assert property (
    (rxStep0 && rxShift[7]) |=> rxShift[0] == $past(sampleBit) && rxShift[7:1] == $past(rxShift[6:0]))
    else $error("Receive shifter did not take the S5P2 sample.");
  AST_ASYNC_ALIGN: assert property (
    ($rose(txSend) && asyncMode) |-> phase == PHASE_S1P2)
    else $error("Async send did not begin at S1P1.");
  AST_START_BIT: assert property (
    $past(asyncMode && txSend && !txDataPhase) |-> !portLineClock)
    else $error("Start bit missing on the transmit line.");
  AST_START_RESET: assert property (
    startEdge |=> rxDiv == 4'h0 && rxShift == RX_LOAD_ASYNC && rxState == RX_START)
    else $error("Start edge did not reset divider and load the shifter.");
  // A flag may fall through a control write, so each check looks one cycle ahead only.
  AST_DONE_STICKY: assert property (
    (txDone && !wrCtrl) |=> txDone)
    else $error("Transmit done flag dropped without software.");
  AST_RXDONE_STICKY: assert property (
    (rxDone && !wrCtrl) |=> rxDone)
    else $error("Receive done flag dropped without software.");
  AST_EVENT_REQUEST: assert property (
    (txDone || rxDone) |=> serialEvent)
    else $error("Event request not raised while a done flag is set.");

  COV_SYNC_TX: cover property ($rose(txDone) && syncMode);
  COV_SYNC_RX: cover property ($rose(rxDone) && syncMode);
  COV_ASYNC_TX: cover property ($rose(txDone) && asyncMode);
  COV_ASYNC_RX: cover property ($rose(rxDone) && asyncMode);

endmodule // sp_serial_port
